// ==== src/vcp_pkg.sv ====
// Constants and types of the virtual interface priority control block
package vcp_pkg;

    // ******************************************************
    // Implementation choices
    // ******************************************************
    localparam int         PRI_BITS   = 5;
    localparam logic [2:0] PRI_FIELD  = 3'(PRI_BITS - 1);
    localparam logic [2:0] ID_W16     = 3'h0;
    localparam logic [2:0] ID_W24     = 3'h1;
    localparam logic [2:0] ID_FIELD   = ID_W16;
    localparam logic       SERR_VAL   = 1'b0;

    // ******************************************************
    // Binary point limits and reset values
    // ******************************************************
    localparam logic [2:0] BP0_MIN  = 3'((PRI_BITS >= 7) ? 0 : 7 - PRI_BITS);
    localparam logic [2:0] BP1_RST  = BP0_MIN + 3'h1;
    localparam logic [2:0] BP_MAX   = 3'h7;
    localparam logic       EOIM_RST = 1'b0;
    localparam logic       CMBP_RST = 1'b0;

    // ******************************************************
    // Access encodings (CRm, op2)
    // ******************************************************
    localparam logic [3:0] CRM_GRP0 = 4'h8;
    localparam logic [3:0] CRM_GRP1 = 4'hc;
    localparam logic [2:0] OP2_BP   = 3'h3;
    localparam logic [2:0] OP2_CTL  = 3'h4;

    // ******************************************************
    // Field positions
    // ******************************************************
    localparam int CTL_SERR   = 14;
    localparam int CTL_ID_LO  = 11;
    localparam int CTL_PRI_LO = 8;
    localparam int CTL_EOIM   = 1;
    localparam int CTL_CMBP   = 0;
    localparam int BP_HI      = 2;
    localparam int ID_HI      = 23;
    localparam int ID_EXT_LO  = 16;

    typedef enum logic [1:0] {
        VCP_SEL_NONE,
        VCP_SEL_BP0,
        VCP_SEL_BP1,
        VCP_SEL_CTL
    } vcp_sel_e;

endpackage : vcp_pkg

// ==== src/vcp_prio_split.sv ====
// Splits an 8-bit priority into its group priority by binary point
`timescale 1ns/100ps
module vcp_prio_split
    import vcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] prio,
    input  wire logic [2:0] bin_point,
    output logic      [7:0] group_prio
);

    logic [7:0] group_prio_nxt;
    logic [3:0] shift;

    // Keep bits above the point; point 7 leaves no group bits
    always_comb
    begin
        shift          = {1'b0, bin_point} + 4'h1;
        group_prio_nxt = prio & (8'hff << shift);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            group_prio <= 8'h00;
        else
            group_prio <= group_prio_nxt;
    end

endmodule : vcp_prio_split

// ==== src/vcp_eoi_ctl.sv ====
// End-of-interrupt and deactivate handling by mode
`timescale 1ns/100ps
module vcp_eoi_ctl
    import vcp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        eoi_mode,
    input  wire logic        eoi_g0_wr,
    input  wire logic        eoi_g1_wr,
    input  wire logic        dir_wr,
    input  wire logic [31:0] wdata,
    output logic             prio_drop,
    output logic             prio_drop_g1,
    output logic             deact,
    output logic             dir_unpred,
    output logic      [23:0] irq_id
);

    logic        prio_drop_nxt;
    logic        prio_drop_g1_nxt;
    logic        deact_nxt;
    logic        dir_unpred_nxt;
    logic [23:0] irq_id_nxt;

    // Mode 0 ends and deactivates; mode 1 splits the two
    always_comb
    begin
        prio_drop_nxt    = eoi_g0_wr | eoi_g1_wr;
        prio_drop_g1_nxt = eoi_g1_wr & ~eoi_g0_wr;
        deact_nxt        = eoi_mode ? dir_wr
                                    : (eoi_g0_wr | eoi_g1_wr);
        dir_unpred_nxt   = ~eoi_mode & dir_wr;
        irq_id_nxt       = wdata[ID_HI:0];
        if (ID_FIELD == ID_W16)
            irq_id_nxt[ID_HI:ID_EXT_LO] = 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prio_drop    <= 1'b0;
            prio_drop_g1 <= 1'b0;
            deact        <= 1'b0;
            dir_unpred   <= 1'b0;
            irq_id       <= 24'h000000;
        end
        else
        begin
            prio_drop    <= prio_drop_nxt;
            prio_drop_g1 <= prio_drop_g1_nxt;
            deact        <= deact_nxt;
            dir_unpred   <= dir_unpred_nxt;
            irq_id       <= irq_id_nxt;
        end
    end

endmodule : vcp_eoi_ctl

// ==== src/vcp_prio_control.sv ====
// Virtual interface binary points, control register, routing and traps
`timescale 1ns/100ps
module vcp_prio_control
    import vcp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        sr_req,
    input  wire logic        sr_wr,
    input  wire logic [3:0]  sr_crm,
    input  wire logic [2:0]  sr_op2,
    input  wire logic [31:0] sr_wdata,
    input  wire logic        sr_from_guest,
    input  wire logic        fast_irq_route_bit,
    input  wire logic        normal_irq_route_bit,
    input  wire logic        sysreg_enable_bit,
    input  wire logic        trap_all_g0_bit,
    input  wire logic        trap_all_g1_bit,
    input  wire logic        nonsecure_state_bit,
    input  wire logic [7:0]  g0_prio,
    input  wire logic [7:0]  g1_prio,
    input  wire logic        eoi_g0_wr,
    input  wire logic        eoi_g1_wr,
    input  wire logic        dir_wr,
    input  wire logic [31:0] eoi_wdata,
    output logic             sr_ack,
    output logic      [31:0] sr_rdata,
    output logic             sr_virt,
    output logic             sr_phys,
    output logic             sr_trap_guest,
    output logic             sr_trap_hyp,
    output logic      [7:0]  g0_group_prio,
    output logic      [7:0]  g1_group_prio,
    output logic             prio_drop,
    output logic             prio_drop_g1,
    output logic             deact,
    output logic             dir_unpred,
    output logic      [23:0] deact_irq_id
);

    // ******************************************************
    // State and next values
    // ******************************************************
    logic [2:0]  bp0_r;
    logic [2:0]  bp0_nxt;
    logic [2:0]  bp1_r;
    logic [2:0]  bp1_nxt;
    logic        eoim_r;
    logic        eoim_nxt;
    logic        cmbp_r;
    logic        cmbp_nxt;
    logic        ack_nxt;
    logic [31:0] rdata_nxt;
    logic        virt_nxt;
    logic        phys_nxt;
    logic        trap_g_nxt;
    logic        trap_h_nxt;

    vcp_sel_e    sel;
    logic        routed;
    logic        hyp_trap;
    logic        wr_virt;
    logic [2:0]  wbp;
    logic [2:0]  bp1_view;
    logic [31:0] ctl_view;
    logic [2:0]  bp_eff [2];
    logic [7:0]  prio_in [2];
    logic [7:0]  grp_out [2];

    // ******************************************************
    // Access decode, routing and traps
    // ******************************************************

    // Which register the encoding names; anything else is unmapped
    always_comb
    begin
        sel = VCP_SEL_NONE;
        if (sr_crm == CRM_GRP0 && sr_op2 == OP2_BP)
            sel = VCP_SEL_BP0;
        else if (sr_crm == CRM_GRP1 && sr_op2 == OP2_BP)
            sel = VCP_SEL_BP1;
        else if (sr_crm == CRM_GRP1 && sr_op2 == OP2_CTL)
            sel = VCP_SEL_CTL;
    end

    // Routing bits pick the virtual or the physical copy
    always_comb
    begin
        unique case (sel)
            VCP_SEL_BP0: routed = fast_irq_route_bit;
            VCP_SEL_BP1: routed = normal_irq_route_bit;
            VCP_SEL_CTL: routed = fast_irq_route_bit
                                | normal_irq_route_bit;
            VCP_SEL_NONE: routed = 1'b0;
        endcase
    end

    // Hypervisor traps apply in the non-secure state only
    always_comb
    begin
        hyp_trap = nonsecure_state_bit
                 & ((sel == VCP_SEL_BP0 & trap_all_g0_bit)
                  | (sel == VCP_SEL_BP1 & trap_all_g1_bit));
    end

    // Outcome of this access; the enable trap outranks the others
    always_comb
    begin
        trap_g_nxt = 1'b0;
        trap_h_nxt = 1'b0;
        virt_nxt   = 1'b0;
        phys_nxt   = 1'b0;
        if (sr_req && sel != VCP_SEL_NONE)
        begin
            if (sr_from_guest && !sysreg_enable_bit)
                trap_g_nxt = 1'b1;
            else if (sr_from_guest && hyp_trap)
                trap_h_nxt = 1'b1;
            // Secure state has no virtual copies, whatever the routing
            else if (sr_from_guest && nonsecure_state_bit && routed)
                virt_nxt = 1'b1;
            else
                phys_nxt = 1'b1;
        end
        ack_nxt = sr_req;
        wr_virt = virt_nxt & sr_wr;
    end

    // ******************************************************
    // Read views
    // ******************************************************

    // Common point makes group 1 read as group 0 plus one, held at 7
    always_comb
    begin
        if (cmbp_r)
            bp1_view = (bp0_r == BP_MAX) ? BP_MAX
                                         : bp0_r + 3'h1;
        else
            bp1_view = bp1_r;
    end

    // Reserved bits read zero; identity fields are constants
    always_comb
    begin
        ctl_view                          = 32'h00000000;
        ctl_view[CTL_SERR]                = SERR_VAL;
        ctl_view[CTL_ID_LO+2:CTL_ID_LO]   = ID_FIELD;
        ctl_view[CTL_PRI_LO+2:CTL_PRI_LO] = PRI_FIELD;
        ctl_view[CTL_EOIM]                = eoim_r;
        ctl_view[CTL_CMBP]                = cmbp_r;
    end

    // Only virtual reads return data; others answer zero
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        if (virt_nxt && !sr_wr)
        begin
            unique case (sel)
                VCP_SEL_BP0: rdata_nxt[BP_HI:0] = bp0_r;
                VCP_SEL_BP1: rdata_nxt[BP_HI:0] = bp1_view;
                VCP_SEL_CTL: rdata_nxt = ctl_view;
                VCP_SEL_NONE: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // ******************************************************
    // Register writes
    // ******************************************************

    // Upper write bits are dropped; a point stores its 3-bit field raised to its minimum (group 1 not while common point is set), the control register bits 1 and 0
    always_comb
    begin
        wbp      = sr_wdata[BP_HI:0];
        bp0_nxt  = bp0_r;
        bp1_nxt  = bp1_r;
        eoim_nxt = eoim_r;
        cmbp_nxt = cmbp_r;
        if (wr_virt)
        begin
            unique case (sel)
                VCP_SEL_BP0:
                    bp0_nxt = (wbp < BP0_MIN) ? BP0_MIN : wbp;
                VCP_SEL_BP1:
                    if (!cmbp_r)
                        bp1_nxt = (wbp < BP1_RST) ? BP1_RST
                                                  : wbp;
                VCP_SEL_CTL:
                begin
                    eoim_nxt = sr_wdata[CTL_EOIM];
                    cmbp_nxt = sr_wdata[CTL_CMBP];
                end
                VCP_SEL_NONE: ;
            endcase
        end
    end

    // Resets: minimum point for group 0, one above for group 1
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bp0_r         <= BP0_MIN;
            bp1_r         <= BP1_RST;
            eoim_r        <= EOIM_RST;
            cmbp_r        <= CMBP_RST;
            sr_ack        <= 1'b0;
            sr_rdata      <= 32'h00000000;
            sr_virt       <= 1'b0;
            sr_phys       <= 1'b0;
            sr_trap_guest <= 1'b0;
            sr_trap_hyp   <= 1'b0;
        end
        else
        begin
            bp0_r         <= bp0_nxt;
            bp1_r         <= bp1_nxt;
            eoim_r        <= eoim_nxt;
            cmbp_r        <= cmbp_nxt;
            sr_ack        <= ack_nxt;
            sr_rdata      <= rdata_nxt;
            sr_virt       <= virt_nxt;
            sr_phys       <= phys_nxt;
            sr_trap_guest <= trap_g_nxt;
            sr_trap_hyp   <= trap_h_nxt;
        end
    end

    // ******************************************************
    // Preemption split per group
    // ******************************************************

    // Common point hands group 0's point to group 1 as well
    always_comb
    begin
        bp_eff[0]  = bp0_r;
        bp_eff[1]  = cmbp_r ? bp0_r : bp1_r;
        prio_in[0] = g0_prio;
        prio_in[1] = g1_prio;
    end

    for (genvar g = 0; g < 2; g++)
    begin : g_split
        vcp_prio_split u_split (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .prio       (prio_in[g]),
            .bin_point  (bp_eff[g]),
            .group_prio (grp_out[g])
        );
    end

    assign g0_group_prio = grp_out[0];
    assign g1_group_prio = grp_out[1];

    // ******************************************************
    // End of interrupt and deactivation
    // ******************************************************

    // Mode bit from the virtual control register steers it
    vcp_eoi_ctl u_eoi (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .eoi_mode     (eoim_r),
        .eoi_g0_wr    (eoi_g0_wr),
        .eoi_g1_wr    (eoi_g1_wr),
        .dir_wr       (dir_wr),
        .wdata        (eoi_wdata),
        .prio_drop    (prio_drop),
        .prio_drop_g1 (prio_drop_g1),
        .deact        (deact),
        .dir_unpred   (dir_unpred),
        .irq_id       (deact_irq_id)
    );

endmodule : vcp_prio_control

// ==== tb/vcp_pe_model.sv ====
// Processor element model issuing system register accesses
`timescale 1ns/100ps
module vcp_pe_model
(
    input  wire logic  clk,
    output logic        sr_req,
    output logic        sr_wr,
    output logic [3:0]  sr_crm,
    output logic [2:0]  sr_op2,
    output logic [31:0] sr_wdata,
    output logic [6:0]  ctl_bits
);
    // Idle bus at time zero
    initial
    begin
        {sr_req, sr_wr, sr_crm, sr_op2, sr_wdata, ctl_bits} = '0;
    end

    // Drive after an edge, hold through the taking edge, then release
    task automatic acc(logic wr, logic [6:0] e, logic [31:0] wd,
                       logic [6:0] c);
        @(posedge clk);
        #1;
        {sr_req, sr_wr, sr_crm, sr_op2, sr_wdata, ctl_bits} =
            {1'b1, wr, e, wd, c};
        @(posedge clk);
        #1;
        // Released lines turn over so stale data never passes as valid
        {sr_req, sr_crm, sr_op2, sr_wdata} = {1'b0, ~e, ~wd};
    endtask : acc
endmodule : vcp_pe_model

// ==== tb/vcp_prio_control_sva.sv ====
// Assertion checker for the virtual interface priority control block
`timescale 1ns/100ps
module vcp_prio_control_chk
    import vcp_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        sr_req,
    input wire logic        sr_wr,
    input wire logic [3:0]  sr_crm,
    input wire logic [2:0]  sr_op2,
    input wire logic        sr_from_guest,
    input wire logic        fast_irq_route_bit,
    input wire logic        normal_irq_route_bit,
    input wire logic        sysreg_enable_bit,
    input wire logic        trap_all_g0_bit,
    input wire logic        trap_all_g1_bit,
    input wire logic        nonsecure_state_bit,
    input wire logic [7:0]  g0_prio,
    input wire logic        eoi_g0_wr,
    input wire logic        eoi_g1_wr,
    input wire logic        dir_wr,
    input wire logic [31:0] eoi_wdata,
    input wire logic        sr_ack,
    input wire logic [31:0] sr_rdata,
    input wire logic        sr_virt,
    input wire logic        sr_phys,
    input wire logic        sr_trap_guest,
    input wire logic        sr_trap_hyp,
    input wire logic [7:0]  g0_group_prio,
    input wire logic [7:0]  g1_group_prio,
    input wire logic        prio_drop,
    input wire logic        deact,
    input wire logic        dir_unpred,
    input wire logic [23:0] deact_irq_id
);
    // Fixed control fields above the two writable bits
    localparam logic [29:0] CTL_RO =
        {16'h0, 1'b0, SERR_VAL, ID_FIELD, PRI_FIELD, 6'h0};
    // Decode of the access being taken
    wire        is_bp0 = sr_crm == CRM_GRP0 && sr_op2 == OP2_BP;
    wire        is_bp1 = sr_crm == CRM_GRP1 && sr_op2 == OP2_BP;
    wire        is_ctl = sr_crm == CRM_GRP1 && sr_op2 == OP2_CTL;
    wire        g_ok   = sr_req && sr_from_guest && sysreg_enable_bit;
    wire        hyp0   = nonsecure_state_bit && trap_all_g0_bit;
    wire        hyp1   = nonsecure_state_bit && trap_all_g1_bit;
    wire [15:0] id_lo  = eoi_wdata[15:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ack_per_req :
        assert property (sr_ack == $past(sr_req)) else $error("ack lost");
    a_guest_trap :
        assert property (sr_req && sr_from_guest && !sysreg_enable_bit &&
            (is_bp0 || is_bp1 || is_ctl) |=> sr_trap_guest && !sr_virt)
        else $error("guest trap missing");
    a_hyp_trap_g0 :
        assert property (g_ok && is_bp0 && hyp0 |=> sr_trap_hyp && !sr_virt)
        else $error("group 0 hyp trap missing");
    a_hyp_trap_g1 :
        assert property (g_ok && is_bp1 && hyp1 |=> sr_trap_hyp && !sr_virt)
        else $error("group 1 hyp trap missing");
    a_bp0_route :
        assert property (g_ok && is_bp0 && !hyp0 |=> sr_phys != sr_virt &&
            sr_virt == $past(fast_irq_route_bit && nonsecure_state_bit))
        else $error("bp0 route");
    a_bp1_route :
        assert property (g_ok && is_bp1 && !hyp1 |=> sr_phys != sr_virt &&
            sr_virt == $past(normal_irq_route_bit && nonsecure_state_bit))
        else $error("bp1 route");
    a_ctl_route :
        assert property (g_ok && is_ctl |=> sr_phys != sr_virt && sr_virt ==
            $past(nonsecure_state_bit &&
                  (fast_irq_route_bit || normal_irq_route_bit)))
        else $error("control route");
    a_ctl_fixed :
        assert property (g_ok && !sr_wr && is_ctl |=> !sr_virt ||
            sr_rdata[31:2] == CTL_RO) else $error("control fixed bits");
    a_bp_read_range :
        assert property (g_ok && !sr_wr && is_bp0 |=> !sr_virt ||
            (sr_rdata[31:3] == 29'h0 && sr_rdata[2:0] >= BP0_MIN))
        else $error("bp0 read range");
    a_sub_bits_clear :
        assert property (1'b1 |=> (g0_group_prio & ~$past(g0_prio)) == 8'h0
            && g0_group_prio[2:0] == 3'h0 && g1_group_prio[2:0] == 3'h0)
        else $error("subpriority bits kept");
    a_drop_on_eoi :
        assert property (eoi_g0_wr || eoi_g1_wr |=> prio_drop && !dir_unpred)
        else $error("eoi without drop");
    a_dir_outcome :
        assert property (dir_wr && !eoi_g0_wr && !eoi_g1_wr |=> !prio_drop &&
            deact != dir_unpred) else $error("deactivate outcome");
    a_id_narrow :
        assert property (eoi_g0_wr || eoi_g1_wr || dir_wr |=>
            deact_irq_id == {8'h00, $past(id_lo)}) else $error("id width");
endmodule : vcp_prio_control_chk

bind vcp_prio_control vcp_prio_control_chk u_chk (.*);

// ==== tb/vcp_prio_control_test.sv ====
// Self-checking bench of the virtual interface priority control block
`timescale 1ns/100ps
module vcp_prio_control_test
    import vcp_pkg::*;
;
    // ******************************************************
    // Signals and expected register state
    // ******************************************************
    logic        clk, sys_rst, sr_req, sr_wr, sr_ack;
    logic [3:0]  sr_crm;
    logic [2:0]  sr_op2, bp0_e, bp1_e;
    logic [31:0] sr_wdata, eoi_wdata, sr_rdata, r, wd;
    logic [6:0]  ctl_bits, c;
    logic        sr_from_guest, fast_irq_route_bit, normal_irq_route_bit;
    logic        sysreg_enable_bit, trap_all_g0_bit, trap_all_g1_bit;
    logic        nonsecure_state_bit, eoi_g0_wr, eoi_g1_wr, dir_wr;
    logic        sr_virt, sr_phys, sr_trap_guest, sr_trap_hyp;
    logic        prio_drop, prio_drop_g1, deact, dir_unpred, eoim_e, cmbp_e;
    logic [7:0]  g0_prio, g1_prio, g0_group_prio, g1_group_prio;
    logic [23:0] deact_irq_id;
    int          n_fail, check_count, seed;
    logic [6:0]  encs [4];

    // Processor state levels travel with each access
    assign {sr_from_guest, fast_irq_route_bit, normal_irq_route_bit,
            sysreg_enable_bit, trap_all_g0_bit, trap_all_g1_bit,
            nonsecure_state_bit} = ctl_bits;

    vcp_prio_control dut (.*);
    vcp_pe_model     pe (.*);

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ******************************************************
    // Expectations and shared tasks
    // ******************************************************
    // Outcome flags and read data; updates the expected registers
    function automatic logic [35:0] exp_acc(logic wr, logic [6:0] e,
                                            logic [31:0] d, logic [6:0] k);
        logic b0, b1, ct, rt;
        b0 = e == {CRM_GRP0, OP2_BP};
        b1 = e == {CRM_GRP1, OP2_BP};
        ct = e == {CRM_GRP1, OP2_CTL};
        rt = b0 ? k[5] : (b1 ? k[4] : (k[5] | k[4]));
        if (!(b0 | b1 | ct))
            return 36'h0;
        if (k[6] && !k[3])
            return {4'h2, 32'h0};
        if (k[6] && k[0] && ((b0 && k[2]) || (b1 && k[1])))
            return {4'h1, 32'h0};
        if (!k[6] || !k[0] || !rt)
            return {4'h4, 32'h0};
        if (wr && b0)
            bp0_e = (d[2:0] < BP0_MIN) ? BP0_MIN : d[2:0];
        if (wr && b1 && !cmbp_e)
            bp1_e = (d[2:0] < BP1_RST) ? BP1_RST : d[2:0];
        if (wr && ct)
            {eoim_e, cmbp_e} = d[1:0];
        if (wr)
            return {4'h8, 32'h0};
        if (b0)
            return {4'h8, 29'h0, bp0_e};
        if (b1)
            return {4'h8, 29'h0, cmbp_e ? ((bp0_e == 3'h7) ? 3'h7
                                        : bp0_e + 3'h1) : bp1_e};
        return {4'h8, 16'h0, 1'b0, SERR_VAL, ID_FIELD, PRI_FIELD, 6'h0,
                eoim_e, cmbp_e};
    endfunction : exp_acc

    // Group priority: subpriority bits below the point cleared
    function automatic logic [7:0] grp(logic [7:0] p, logic [2:0] n);
        return p & (8'hff << ({1'b0, n} + 4'h1));
    endfunction : grp

    task automatic chk(string what, logic [35:0] seen, logic [35:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic access(logic wr, logic [6:0] e, logic [31:0] d,
                          logic [6:0] k);
        logic [35:0] x;
        x = exp_acc(wr, e, d, k);
        pe.acc(wr, e, d, k);
        chk("ack", {35'h0, sr_ack}, 36'h1);
        chk("answer", {sr_virt, sr_phys, sr_trap_guest, sr_trap_hyp,
            sr_rdata}, x);
    endtask : access

    // New priorities, judged one registered cycle later
    task automatic split();
        @(posedge clk);
        #1;
        g0_prio = 8'($random(seed));
        g1_prio = 8'($random(seed));
        @(posedge clk);
        #1;
        chk("g0 group", {28'h0, g0_group_prio}, {28'h0, grp(g0_prio, bp0_e)});
        chk("g1 group", {28'h0, g1_group_prio},
            {28'h0, grp(g1_prio, cmbp_e ? bp0_e : bp1_e)});
    endtask : split

    // Kind 0 eoi group 0, 1 eoi group 1, 2 deactivate
    task automatic eoi(logic [1:0] kd, logic [31:0] d);
        @(posedge clk);
        #1;
        {eoi_g0_wr, eoi_g1_wr, dir_wr} = {kd == 2'h0, kd == 2'h1, kd == 2'h2};
        eoi_wdata = d;
        @(posedge clk);
        #1;
        {eoi_g0_wr, eoi_g1_wr, dir_wr, eoi_wdata} = {3'h0, ~d};
        chk("eoi", {prio_drop, prio_drop_g1, deact, dir_unpred, deact_irq_id},
            {kd != 2'h2, kd == 2'h1, (kd == 2'h2) == eoim_e,
             kd == 2'h2 && !eoim_e, 8'h0, d[15:0]});
    endtask : eoi

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // ******************************************************
    // Main sequence
    // ******************************************************
    initial
    begin
        {seed, n_fail, check_count, sys_rst} = {32'h16, 64'h0, 1'b1};
        {g0_prio, g1_prio, eoi_g0_wr, eoi_g1_wr, dir_wr, eoi_wdata} = '0;
        {bp0_e, bp1_e, eoim_e, cmbp_e} =
            {BP0_MIN, BP1_RST, EOIM_RST, CMBP_RST};
        encs = '{{CRM_GRP0, OP2_BP}, {CRM_GRP1, OP2_BP}, {CRM_GRP1, OP2_CTL},
                 7'h59};
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        access(1'b0, encs[0], 32'h0, 7'h78);
        for (int i = 0; i < 3; i++)
            access(1'b0, encs[i], 32'h0, 7'h79);
        access(1'b1, encs[2], 32'hffff_fffe, 7'h79);
        access(1'b0, encs[2], 32'h0, 7'h79);
        access(1'b1, encs[0], 32'h7, 7'h79);
        access(1'b1, encs[1], 32'h0, 7'h79);
        access(1'b0, encs[1], 32'h0, 7'h79);
        split();
        access(1'b1, encs[2], 32'h1, 7'h79);
        access(1'b1, encs[1], 32'h5, 7'h79);
        access(1'b0, encs[1], 32'h0, 7'h79);
        split();
        $display("test corners done");
        for (int i = 0; i < 400; i++)
        begin
            r = $random(seed);
            wd = $random(seed);
            c = r[6:0] | ((r[9:8] != 2'h0) ? 7'h48 : 7'h00);
            access(r[12], encs[r[11:10]], wd, c);
            split();
            eoi(2'(r[15:13] % 3'h3), wd);
        end
        $display("test random done");
        results();
    end
endmodule : vcp_prio_control_test
